// file: hbi_defines.svh
// Purpose: Constants for the host bus interface block
// Assumes: 40 MHz sys_clk
// Notes:   Register count, widths and grant delay of the bus interface
`ifndef HBI_DEFINES_SVH
`define HBI_DEFINES_SVH
`define HBI_REG_COUNT     16
`define HBI_SEL_W         4
`define HBI_AD_W          16
`define HBI_BYTE_W        8
`define HBI_ACK_DELAY     2'h2
`endif

// file: hbi_pkg.sv
// Purpose: Types for the host bus interface block
// Assumes: Used with hbi_defines.svh
// Notes:   Master cycle phases as one-hot states
package hbi_pkg;
  typedef enum logic [4:0] {
    HBI_IDLE = 5'b0_0001,
    HBI_T1   = 5'b0_0010,
    HBI_T2   = 5'b0_0100,
    HBI_T3   = 5'b0_1000,
    HBI_T4   = 5'b1_0000
  } hbi_phase_t;
endpackage

// file: hbi_reg_mem.sv
// Purpose: Sixteen-entry internal register store
// Assumes: Single clock, registered read data
// Notes:   Write and read share one select
`timescale 1ns/1ps
`include "hbi_defines.svh"
module hbi_reg_mem (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   wr_en,
  input  wire logic [`HBI_SEL_W-1:0]  sel,
  input  wire logic [`HBI_BYTE_W-1:0] wr_data,
  output logic      [`HBI_BYTE_W-1:0] rd_data
);
  logic [`HBI_BYTE_W-1:0] mem_reg [`HBI_REG_COUNT];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem_reg[sel] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem_reg[sel];
    end
  end
endmodule // hbi_reg_mem

// file: hbi_host_bus.sv
// Purpose: Slave register port and master memory cycles of the host bus
// Assumes: All pin inputs are asynchronous to sys_clk
// Notes:   One master cycle runs t1..t4, one sys_clk per phase
`timescale 1ns/1ps
`include "hbi_defines.svh"
module hbi_host_bus (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  chip_select_n,
  input  wire logic [`HBI_SEL_W-1:0] register_select_lines,
  input  wire logic                  slave_read_strobe_n,
  input  wire logic                  slave_write_strobe_n,
  input  wire logic                  address_strobe_zero_in,
  input  wire logic                  bus_grant,
  input  wire logic                  dma_active,
  input  wire logic [`HBI_AD_W-1:0]  muxed_addr_data_lines_in,
  input  wire logic                  mem_req,
  input  wire logic                  mem_write,
  input  wire logic                  word_mode,
  input  wire logic                  remote_write,
  input  wire logic [`HBI_AD_W-1:0]  mem_addr,
  input  wire logic [`HBI_AD_W-1:0]  mem_wdata,
  output logic      [`HBI_AD_W-1:0]  muxed_addr_data_lines_out,
  output logic      [`HBI_AD_W-1:0]  muxed_addr_data_lines_oe,
  output logic                       address_strobe_zero_out,
  output logic                       address_strobe_zero_oe,
  output logic                       master_read_strobe_n,
  output logic                       master_write_strobe_n,
  output logic                       master_strobe_oe,
  output logic                       port_latch_read_strobe_n,
  output logic                       access_grant_n,
  output logic      [`HBI_AD_W-1:0]  mem_rdata,
  output logic                       mem_done
);
  // Two-stage synchronisers for all pin inputs
  logic [5:0]  pin_s1_reg;
  logic [5:0]  pin_s2_reg;
  logic [3:0]  rsel_s1_reg;
  logic [3:0]  rsel_s2_reg;
  logic [15:0] ad_s1_reg;
  logic [15:0] ad_s2_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_s1_reg  <= 6'h3f;
      pin_s2_reg  <= 6'h3f;
      rsel_s1_reg <= 4'h0;
      rsel_s2_reg <= 4'h0;
      ad_s1_reg   <= 16'h0000;
      ad_s2_reg   <= 16'h0000;
    end else begin
      pin_s1_reg  <= {~bus_grant, dma_active, chip_select_n, slave_read_strobe_n, slave_write_strobe_n,
                      address_strobe_zero_in};
      pin_s2_reg  <= pin_s1_reg;
      rsel_s1_reg <= register_select_lines;
      rsel_s2_reg <= rsel_s1_reg;
      ad_s1_reg   <= muxed_addr_data_lines_in;
      ad_s2_reg   <= ad_s1_reg;
    end
  end

  logic grant_s;
  logic dma_s;
  logic cs_n_s;
  logic srd_n_s;
  logic swr_n_s;
  logic ads_s;
  assign grant_s = ~pin_s2_reg[5];
  assign dma_s   = pin_s2_reg[4];
  assign cs_n_s  = pin_s2_reg[3];
  assign srd_n_s = pin_s2_reg[2];
  assign swr_n_s = pin_s2_reg[1];
  assign ads_s   = pin_s2_reg[0];

  logic slave_mode;
  assign slave_mode = ~cs_n_s & ~dma_s;

  // Register select latch, flows while strobe high
  logic [3:0] rsel_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsel_reg <= 4'h0;
    end else if (slave_mode && ads_s) begin
      rsel_reg <= rsel_s2_reg;
    end
  end

  // Previous strobe levels for edge detect
  logic swr_n_d_reg;
  logic srd_n_d_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      swr_n_d_reg <= 1'b1;
      srd_n_d_reg <= 1'b1;
    end else begin
      swr_n_d_reg <= swr_n_s;
      srd_n_d_reg <= srd_n_s;
    end
  end

  logic wr_rise;
  assign wr_rise = slave_mode & swr_n_s & ~swr_n_d_reg;

  logic [7:0] rd_data;
  hbi_reg_mem u_mem (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr_en   (wr_rise),
    .sel     (rsel_reg),
    .wr_data (ad_s2_reg[7:0]),
    .rd_data (rd_data)
  );

  // Access grant after a short synchronising wait
  logic [1:0] ack_cnt_reg;
  logic       slave_busy;
  assign slave_busy = slave_mode & (~srd_n_s | ~swr_n_s);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_cnt_reg    <= 2'h0;
      access_grant_n <= 1'b1;
    end else if (!slave_busy) begin
      ack_cnt_reg    <= 2'h0;
      access_grant_n <= 1'b1;
    end else if (ack_cnt_reg != `HBI_ACK_DELAY) begin
      ack_cnt_reg    <= ack_cnt_reg + 2'h1;
    end else begin
      access_grant_n <= 1'b0;
    end
  end

  // Master cycle phase machine
  hbi_pkg::hbi_phase_t phase_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_reg <= hbi_pkg::HBI_IDLE;
    end else begin
      case (phase_reg)
        hbi_pkg::HBI_IDLE: phase_reg <= (grant_s && mem_req) ? hbi_pkg::HBI_T1 : hbi_pkg::HBI_IDLE;
        hbi_pkg::HBI_T1:   phase_reg <= hbi_pkg::HBI_T2;
        hbi_pkg::HBI_T2:   phase_reg <= hbi_pkg::HBI_T3;
        hbi_pkg::HBI_T3:   phase_reg <= hbi_pkg::HBI_T4;
        default:           phase_reg <= hbi_pkg::HBI_IDLE;
      endcase
    end
  end

  logic start_cycle;
  logic in_data;
  assign start_cycle = (phase_reg == hbi_pkg::HBI_IDLE) && grant_s && mem_req;
  assign in_data = (phase_reg == hbi_pkg::HBI_T1) || (phase_reg == hbi_pkg::HBI_T2);

  logic wr_cyc_reg;
  logic word_reg;
  logic rem_reg;
  logic [15:0] addr_reg;
  logic [15:0] wdata_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_cyc_reg <= 1'b0;
      word_reg   <= 1'b0;
      rem_reg    <= 1'b0;
      addr_reg   <= 16'h0000;
      wdata_reg  <= 16'h0000;
    end else if (start_cycle) begin
      wr_cyc_reg <= mem_write;
      word_reg   <= word_mode;
      rem_reg    <= remote_write & mem_write;
      addr_reg   <= mem_addr;
      wdata_reg  <= mem_wdata;
    end
  end

  // Bus drive: t1 address, then data per mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      muxed_addr_data_lines_out <= 16'h0000;
      muxed_addr_data_lines_oe  <= 16'h0000;
    end else if (start_cycle) begin
      muxed_addr_data_lines_out <= mem_addr;
      muxed_addr_data_lines_oe  <= 16'hffff;
    end else if (phase_reg == hbi_pkg::HBI_T1) begin
      if (word_reg) begin
        muxed_addr_data_lines_out <= wdata_reg;
        muxed_addr_data_lines_oe  <= {16{wr_cyc_reg & ~rem_reg}};
      end else begin
        muxed_addr_data_lines_out <= {addr_reg[15:8], wdata_reg[7:0]};
        muxed_addr_data_lines_oe  <= {8'hff, {8{wr_cyc_reg & ~rem_reg}}};
      end
    end else if (in_data) begin
      muxed_addr_data_lines_out <= muxed_addr_data_lines_out;
    end else if (phase_reg == hbi_pkg::HBI_T3) begin
      muxed_addr_data_lines_out <= 16'h0000;
      muxed_addr_data_lines_oe  <= 16'h0000;
    end else if (slave_mode && !srd_n_s && !access_grant_n) begin
      muxed_addr_data_lines_out <= {8'h00, rd_data};
      muxed_addr_data_lines_oe  <= 16'h00ff;
    end else begin
      muxed_addr_data_lines_out <= 16'h0000;
      muxed_addr_data_lines_oe  <= 16'h0000;
    end
  end

  // Address strobe out and master strobes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      address_strobe_zero_out  <= 1'b0;
      address_strobe_zero_oe   <= 1'b0;
      master_read_strobe_n     <= 1'b1;
      master_write_strobe_n    <= 1'b1;
      master_strobe_oe         <= 1'b0;
      port_latch_read_strobe_n <= 1'b1;
    end else begin
      address_strobe_zero_out  <= start_cycle;
      address_strobe_zero_oe   <= grant_s;
      master_strobe_oe         <= grant_s;
      master_write_strobe_n    <= ~(in_data & wr_cyc_reg);
      master_read_strobe_n     <= ~(in_data & ~wr_cyc_reg);
      port_latch_read_strobe_n <= ~(in_data & rem_reg);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem_rdata <= 16'h0000;
      mem_done  <= 1'b0;
    end else begin
      mem_done <= (phase_reg == hbi_pkg::HBI_T4);
      // Synced bus lags two cycles: t4 sees the t2 sample
      if (phase_reg == hbi_pkg::HBI_T4 && !wr_cyc_reg) begin
        mem_rdata <= word_reg ? ad_s2_reg : {8'h00, ad_s2_reg[7:0]};
      end
    end
  end

  a_grant_strobes: assert property (@(posedge sys_clk) disable iff (rst)
    !grant_s |=> !master_strobe_oe) else $error("master strobes driven without grant");
  a_t1_address: assert property (@(posedge sys_clk) disable iff (rst)
    start_cycle |=> (muxed_addr_data_lines_out == $past(mem_addr)) && address_strobe_zero_out)
    else $error("address not driven in t1");
  a_write_low: assert property (@(posedge sys_clk) disable iff (rst)
    (phase_reg == hbi_pkg::HBI_T1 && wr_cyc_reg) |=> !master_write_strobe_n [*2] ##1 master_write_strobe_n)
    else $error("write strobe timing wrong");
  a_read_dir: assert property (@(posedge sys_clk) disable iff (rst)
    !(master_read_strobe_n == 1'b0 && master_write_strobe_n == 1'b0)) else $error("both strobes low");
  a_slave_upper: assert property (@(posedge sys_clk) disable iff (rst)
    (phase_reg == hbi_pkg::HBI_IDLE && $past(phase_reg) == hbi_pkg::HBI_IDLE)
    |-> muxed_addr_data_lines_oe[15:8] == 8'h00) else $error("upper byte driven in slave");
  a_byte_addr: assert property (@(posedge sys_clk) disable iff (rst)
    (phase_reg == hbi_pkg::HBI_T1 && !word_reg) |=> muxed_addr_data_lines_out[15:8] == addr_reg[15:8])
    else $error("high address byte lost");
  a_port_strobe: assert property (@(posedge sys_clk) disable iff (rst)
    !port_latch_read_strobe_n |-> !master_write_strobe_n) else $error("port strobe outside write");
  a_ack_wait: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(slave_busy) |-> access_grant_n [*3]) else $error("grant too early");
  a_slave_drive: assert property (@(posedge sys_clk) disable iff (rst)
    (phase_reg == hbi_pkg::HBI_IDLE && !start_cycle && slave_mode && !srd_n_s && !access_grant_n)
    |=> (muxed_addr_data_lines_oe == 16'h00ff) && (muxed_addr_data_lines_out[7:0] == $past(rd_data)))
    else $error("register data not driven on low byte");
  a_sel_flow: assert property (@(posedge sys_clk) disable iff (rst)
    (slave_mode && ads_s) |=> rsel_reg == $past(rsel_s2_reg))
    else $error("select latch not transparent");
  a_sel_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !(slave_mode && ads_s) |=> $stable(rsel_reg))
    else $error("select latch changed while closed");
  a_ack_release: assert property (@(posedge sys_clk) disable iff (rst)
    !slave_busy |=> access_grant_n)
    else $error("grant held without strobe");
  a_word_data: assert property (@(posedge sys_clk) disable iff (rst)
    (phase_reg == hbi_pkg::HBI_T1 && word_reg && wr_cyc_reg && !rem_reg)
    |=> (muxed_addr_data_lines_oe == 16'hffff) && (muxed_addr_data_lines_out == $past(wdata_reg)))
    else $error("word data not on all lines");
  a_remote_float: assert property (@(posedge sys_clk) disable iff (rst)
    (phase_reg == hbi_pkg::HBI_T1 && rem_reg) |=> muxed_addr_data_lines_oe[7:0] == 8'h00)
    else $error("low byte driven during remote write");
  a_read_low: assert property (@(posedge sys_clk) disable iff (rst)
    (phase_reg == hbi_pkg::HBI_T1 && !wr_cyc_reg) |=> !master_read_strobe_n [*2] ##1 master_read_strobe_n)
    else $error("read strobe timing wrong");
  a_addr_strobe: assert property (@(posedge sys_clk) disable iff (rst)
    (phase_reg != hbi_pkg::HBI_T1) |-> !address_strobe_zero_out)
    else $error("address strobe outside t1");
endmodule // hbi_host_bus

// file: hbi_bus_model.sv
// Purpose: Host data lines and buffer memory on the shared bus
// Assumes: Device output enable wins on each bit
// Notes:   Released lines show the inverse of the last cycle
`timescale 1ns/1ps
module hbi_bus_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] dev_out,
  input  wire logic [15:0] dev_oe,
  input  wire logic        ads_out,
  input  wire logic        ads_oe,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        stb_oe,
  input  wire logic        host_drv,
  input  wire logic [15:0] host_data,
  output logic      [15:0] bus
);
  logic [15:0] mem [256];
  logic [15:0] addr_reg = 16'h0000;
  logic [15:0] last_reg = 16'h0000;
  logic [1:0]  hold_reg = 2'h0;
  logic [15:0] far;
  always @* begin
    far = host_drv ? host_data : ~last_reg;
    if ((stb_oe && !rd_n) || hold_reg != 2'h0)
      far = mem[addr_reg[7:0]];
    bus = (dev_oe & dev_out) | (~dev_oe & far);
  end
  always @(posedge sys_clk) begin
    last_reg <= bus;
    if (ads_oe && ads_out)
      addr_reg <= bus;
    if (stb_oe && !wr_n)
      mem[addr_reg[7:0]] <= bus;
    hold_reg <= (stb_oe && !rd_n) ? 2'h3 : hold_reg - {1'b0, hold_reg != 2'h0};
  end
endmodule // hbi_bus_model

// file: tb_hbi_host_bus.sv
// Purpose: Self-checking bench for the host bus block
// Assumes: Inputs change on falling sys_clk
// Notes:   Expected values come from integer models
`timescale 1ns/1ps
`include "hbi_defines.svh"
module tb_hbi_host_bus;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cs_n = 1'b1, srd_n = 1'b1, swr_n = 1'b1, ads_h = 1'b1;
  logic        grant = 1'b0, dma = 1'b0, req = 1'b0, wr = 1'b0;
  logic        word = 1'b0, rwr = 1'b0, hdrv = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, hdata = 16'h0000, exp_v;
  wire  [15:0] ad_bus, ad_out, ad_oe, rdata;
  wire         ads_out, ads_oe, mrd_n, mwr_n, stb_oe, prd_n, ack_n, done;
  wire         ads_pin = ads_oe ? ads_out : ads_h;
  int          err_total = 0, check_count = 0, seed = 32'hb8ff, i, k;
  int          reg_model [16];
  always #12.5 sys_clk = ~sys_clk;
  hbi_host_bus dut_u (.sys_clk(sys_clk), .rst(rst), .chip_select_n(cs_n),
    .register_select_lines(sel), .slave_read_strobe_n(srd_n), .slave_write_strobe_n(swr_n),
    .address_strobe_zero_in(ads_pin), .bus_grant(grant), .dma_active(dma),
    .muxed_addr_data_lines_in(ad_bus), .mem_req(req), .mem_write(wr), .word_mode(word),
    .remote_write(rwr), .mem_addr(addr), .mem_wdata(wdata), .muxed_addr_data_lines_out(ad_out),
    .muxed_addr_data_lines_oe(ad_oe), .address_strobe_zero_out(ads_out),
    .address_strobe_zero_oe(ads_oe), .master_read_strobe_n(mrd_n), .master_write_strobe_n(mwr_n),
    .master_strobe_oe(stb_oe), .port_latch_read_strobe_n(prd_n), .access_grant_n(ack_n),
    .mem_rdata(rdata), .mem_done(done));
  hbi_bus_model far_u (.sys_clk(sys_clk), .dev_out(ad_out), .dev_oe(ad_oe), .ads_out(ads_out),
    .ads_oe(ads_oe), .rd_n(mrd_n), .wr_n(mwr_n), .stb_oe(stb_oe), .host_drv(hdrv),
    .host_data(hdata), .bus(ad_bus));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Host register access; blk expects no grant
  task automatic slave(input logic w, input logic [3:0] r, input logic [7:0] d, input logic blk);
    @(negedge sys_clk);
    cs_n = 1'b0;
    sel = r;
    hdrv = w;
    hdata = 16'($random(seed));
    hdata[7:0] = d;
    repeat (3) @(negedge sys_clk);
    ads_h = 1'b0;
    @(negedge sys_clk);
    swr_n = ~w;
    srd_n = w;
    for (k = 0; k < 30 && (blk || ack_n !== 1'b0); k++) @(negedge sys_clk);
    check("ack", {15'h0000, ack_n}, {15'h0000, blk});
    sel = ~r;
    repeat (2) @(negedge sys_clk);
    if (!w && !blk) begin
      check("rd_data", {8'h00, ad_out[7:0]}, {8'h00, d});
      check("rd_oe", ad_oe, 16'h00ff);
    end
    swr_n = 1'b1;
    srd_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    hdrv = 1'b0;
    cs_n = 1'b1;
    ads_h = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic mcycle(input logic w);
    wr = w;
    req = 1'b1;
    @(negedge sys_clk);
    req = 1'b0;
    for (k = 0; k < 20 && done !== 1'b1; k++) @(negedge sys_clk);
    check("done", {15'h0000, done}, 16'h0001);
    repeat (2) @(negedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    if (!rst && ads_oe && ads_out) begin
      check("t1_addr", ad_out, addr);
      check("t1_oe", ad_oe, 16'hffff);
    end
    if (!rst && stb_oe && !(mrd_n && mwr_n)) begin
      check("dir", {14'h0000, mwr_n, mrd_n}, wr ? 16'h0001 : 16'h0002);
      if (!word)
        check("hi_addr", {ad_out[15:8], ad_oe[15:8]}, {addr[15:8], 8'hff});
      if (wr)
        check("wdata", ad_out, word ? wdata : {addr[15:8], wdata[7:0]});
    end
    if (!rst)
      check("prd", {15'h0000, prd_n}, {15'h0000, mwr_n | ~rwr});
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    check("oe_rst", ad_oe | {14'h0000, ads_oe, stb_oe}, 16'h0000);
    repeat (4) @(negedge sys_clk);
    for (i = 0; i < 16; i++) begin
      reg_model[i] = $random(seed) & 8'hff;
      slave(1'b1, i[3:0], reg_model[i][7:0], 1'b0);
    end
    dma = 1'b1;
    slave(1'b1, 4'h5, ~reg_model[5][7:0], 1'b1);
    dma = 1'b0;
    for (i = 0; i < 16; i++)
      slave(1'b0, i[3:0], reg_model[i][7:0], 1'b0);
    check("no_grant", {14'h0000, ads_oe, stb_oe}, 16'h0000);
    grant = 1'b1;
    repeat (4) @(negedge sys_clk);
    for (i = 0; i < 8; i++) begin
      word = i[0];
      rwr = i[1];
      addr = 16'($random(seed));
      wdata = 16'($random(seed));
      // External latch supplies the data in a remote write
      hdrv = rwr;
      hdata = wdata;
      mcycle(1'b1);
      hdrv = 1'b0;
      exp_v = word ? wdata : {8'h00, wdata[7:0]};
      mcycle(1'b0);
      check("rdata", word ? rdata : {8'h00, rdata[7:0]}, exp_v);
    end
    grant = 1'b0;
    repeat (5) @(negedge sys_clk);
    check("released", {14'h0000, ads_oe, stb_oe}, 16'h0000);
    summarize();
  end
  initial begin
    #(5000 * 25);
    err_total++;
    summarize();
  end
endmodule // tb_hbi_host_bus
